// ---- hw/aic_ctrl.sv ----
// Converter interrupt flags, overrun flags, clock code, power and reference pin routing
// Summary of operation
// - Continue off: flag set blocks further interrupts
// - Continue on: interrupts keep coming despite flag
// - Event coinciding with clear leaves flag set
// - Writing one to flag-clear clears flag
// - Event while flag set raises overrun
// - Writing one to overrun-clear clears overrun
// - Divider code picks half-step clock ratio
// - No open/short detect register exists
// - Reference pins selectable as input channels (high pin on instances D and E only)
//
// Register access over APB and the placing of the registers are this design's own decisions.
`default_nettype none
`include "aic_regs.svh"
module aic_ctrl #(
  parameter aic_pkg::aic_inst_e INSTANCE = aic_pkg::AIC_INST_A
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] eoc_pulse,
  output logic [3:0] irq_pulse,
  output logic converter_power_on,
  output logic conversion_clock,
  output logic [4:0] chan_select,
  output logic ref_high_pin_route,
  output logic ref_low_pin_route
);

  aic_pkg::aic_state_s st;
  aic_pkg::aic_state_s nx;
  aic_div_if div_link ();
  logic wr;
  logic setup;
  logic hit;
  logic [3:0] ev;
  logic [3:0] next_flag;
  logic [3:0] next_ovf;
  logic [3:0] next_irq;
  logic hi_ok;
  logic [4:0] lo_chan;

  assign wr = psel && penable && pwrite;
  assign setup = psel && !penable;
  // Register file answers with no wait states
  assign pready = 1'b1;

  // Open/short detect offset is deliberately left undecoded
  always_comb
  begin
    unique case (paddr)
      `AIC_OFS_CTL1, `AIC_OFS_CTL2, `AIC_OFS_SEL12, `AIC_OFS_SEL34,
      `AIC_OFS_FLG, `AIC_OFS_FLGCLR, `AIC_OFS_OVF, `AIC_OFS_OVFCLR,
      `AIC_OFS_CHAN: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !hit;

  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_line
      logic clr;
      logic oclr;
      assign ev[i] = st.line[i].en && eoc_pulse[st.line[i].src];
      assign clr = wr && paddr == `AIC_OFS_FLGCLR && pwdata[i];
      assign oclr = wr && paddr == `AIC_OFS_OVFCLR && pwdata[i];
      // Set wins over a simultaneous clear
      assign next_flag[i] = ev[i] || (st.flag[i] && !clr);
      assign next_ovf[i] = (ev[i] && st.flag[i]) || (st.ovf[i] && !oclr);
      // Old flag decides: a colliding clear does not reopen the line
      assign next_irq[i] = ev[i] && (!st.flag[i] || st.line[i].cont);

      property p_block;
        @(posedge pclk) disable iff (!presetn)
        (ev[i] && st.flag[i] && !st.line[i].cont) |=> !irq_pulse[i];
      endproperty
      a_block: assert property (p_block) else $error("interrupt passed a set flag");

      property p_cont;
        @(posedge pclk) disable iff (!presetn)
        (ev[i] && st.line[i].cont) |=> irq_pulse[i];
      endproperty
      a_cont: assert property (p_cont) else $error("continue mode lost an interrupt");

      // Flag survives the collision and drops only on a later clear
      sequence s_flag_kept;
        st.flag[i] ##1 (st.flag[i] || $past(clr));
      endsequence

      property p_collide;
        @(posedge pclk) disable iff (!presetn)
        (ev[i] && clr) |=> s_flag_kept;
      endproperty
      a_collide: assert property (p_collide) else $error("colliding clear dropped the flag");

      property p_clear;
        @(posedge pclk) disable iff (!presetn)
        (clr && !ev[i]) |=> !st.flag[i];
      endproperty
      a_clear: assert property (p_clear) else $error("flag clear write ignored");

      property p_ovf_set;
        @(posedge pclk) disable iff (!presetn)
        (ev[i] && st.flag[i]) |=> st.ovf[i] && st.flag[i];
      endproperty
      a_ovf_set: assert property (p_ovf_set) else $error("lost interrupt not flagged");

      property p_ovf_hold;
        @(posedge pclk) disable iff (!presetn)
        (st.ovf[i] && !oclr) |=> st.ovf[i];
      endproperty
      a_ovf_hold: assert property (p_ovf_hold) else $error("overrun dropped without clear");

      property p_ovf_clr;
        @(posedge pclk) disable iff (!presetn)
        (oclr && !(ev[i] && st.flag[i])) |=> !st.ovf[i];
      endproperty
      a_ovf_clr: assert property (p_ovf_clr) else $error("overrun clear write ignored");

      property p_first;
        @(posedge pclk) disable iff (!presetn)
        (ev[i] && !st.flag[i]) |=> irq_pulse[i] && st.flag[i];
      endproperty
      a_first: assert property (p_first) else $error("first event gave no interrupt");
    end
  endgenerate

  // Reference pins double as inputs only on the supply reference, the high pin only on instances D and E
  assign hi_ok = INSTANCE == aic_pkg::AIC_INST_D || INSTANCE == aic_pkg::AIC_INST_E;
  assign lo_chan = (INSTANCE == aic_pkg::AIC_INST_D) ? `AIC_LO_CHAN_D : `AIC_LO_CHAN;
  always_comb
  begin
    nx = st;
    nx.flag = next_flag;
    nx.ovf = next_ovf;
    nx.irq = next_irq;
    if (wr)
    begin
      unique case (paddr)
        `AIC_OFS_CTL1:
        begin
          nx.power = pwdata[`AIC_PWR_BIT];
          nx.refsel = pwdata[`AIC_REFSEL_BIT];
        end
        `AIC_OFS_CTL2: nx.code = pwdata[`AIC_CODE_MSB:0];
        `AIC_OFS_SEL12:
        begin
          nx.line[0] = aic_pkg::aic_line_s'(pwdata[`AIC_LINE_MSB:0]);
          nx.line[1] = aic_pkg::aic_line_s'(pwdata[`AIC_LINE_STRIDE +: 6]);
        end
        `AIC_OFS_SEL34:
        begin
          nx.line[2] = aic_pkg::aic_line_s'(pwdata[`AIC_LINE_MSB:0]);
          nx.line[3] = aic_pkg::aic_line_s'(pwdata[`AIC_LINE_STRIDE +: 6]);
        end
        `AIC_OFS_CHAN: nx.chan = pwdata[`AIC_CHAN_MSB:0];
        default:
        begin
        end
      endcase
    end
    nx.rdata = 32'h00000000;
    if (setup && !pwrite)
    begin
      unique case (paddr)
        `AIC_OFS_CTL1: nx.rdata = {30'h00000000, st.refsel, st.power};
        `AIC_OFS_CTL2: nx.rdata = {28'h0000000, st.code};
        `AIC_OFS_SEL12: nx.rdata = {16'h0000, 2'h0, st.line[1], 2'h0, st.line[0]};
        `AIC_OFS_SEL34: nx.rdata = {16'h0000, 2'h0, st.line[3], 2'h0, st.line[2]};
        `AIC_OFS_FLG: nx.rdata = {28'h0000000, st.flag};
        `AIC_OFS_OVF: nx.rdata = {28'h0000000, st.ovf};
        `AIC_OFS_CHAN: nx.rdata = {27'h0000000, st.chan};
        default: nx.rdata = 32'h00000000;
      endcase
    end
    nx.ref_hi = st.refsel && hi_ok && st.chan == `AIC_HI_CHAN;
    nx.ref_lo = st.refsel && st.chan == lo_chan;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.code <= `AIC_RST_CODE;
      st.chan <= `AIC_RST_CHAN;
    end
    else
      st <= nx;
  end

  assign div_link.code = st.code;
  assign div_link.power = st.power;

  aic_clk_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .dv(div_link.div)
  );

  assign prdata = st.rdata;
  assign irq_pulse = st.irq;
  assign converter_power_on = st.power;
  assign conversion_clock = div_link.tick;
  assign chan_select = st.chan;
  assign ref_high_pin_route = st.ref_hi;
  assign ref_low_pin_route = st.ref_lo;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_no_osd;
    (psel && penable && paddr == `AIC_OFS_OSD) |-> pslverr;
  endproperty
  a_no_osd: assert property (p_no_osd) else $error("open/short detect offset answered");

  property p_ref_hi;
    (st.refsel && hi_ok && st.chan == `AIC_HI_CHAN) |=> ref_high_pin_route;
  endproperty
  a_ref_hi: assert property (p_ref_hi) else $error("high reference pin not routed");

  property p_ref_lo;
    (!st.refsel || st.chan != lo_chan) |=> !ref_low_pin_route;
  endproperty
  a_ref_lo: assert property (p_ref_lo) else $error("low reference pin routed wrongly");

endmodule // aic_ctrl
`default_nettype wire

// ---- include/aic_regs.svh ----
// Register offsets, field positions, reset values and channel numbers of the converter control
`ifndef AIC_REGS_SVH
`define AIC_REGS_SVH

`define AIC_OFS_CTL1 8'h00
`define AIC_OFS_CTL2 8'h04
`define AIC_OFS_SEL12 8'h08
`define AIC_OFS_SEL34 8'h0C
`define AIC_OFS_FLG 8'h10
`define AIC_OFS_FLGCLR 8'h14
`define AIC_OFS_OVF 8'h18
`define AIC_OFS_OVFCLR 8'h1C
`define AIC_OFS_CHAN 8'h20
`define AIC_OFS_OSD 8'h24

`define AIC_PWR_BIT 0
`define AIC_REFSEL_BIT 1
`define AIC_CODE_MSB 3
`define AIC_LINE_STRIDE 8
`define AIC_LINE_MSB 5
`define AIC_CHAN_MSB 4

`define AIC_RST_CODE 4'h0
`define AIC_RST_CHAN 5'h00
`define AIC_RST_LINE 6'h00

`define AIC_HI_CHAN 5'h14
`define AIC_LO_CHAN 5'h0D
`define AIC_LO_CHAN_D 5'h01

`endif

// ---- include/aic_pkg.sv ----
// Types of the converter interrupt flag and clock control
`default_nettype none
package aic_pkg;

  typedef enum logic [2:0] {
    AIC_INST_A = 3'h0,
    AIC_INST_B = 3'h1,
    AIC_INST_C = 3'h2,
    AIC_INST_D = 3'h3,
    AIC_INST_E = 3'h4
  } aic_inst_e;

  typedef struct packed {
    logic cont;
    logic en;
    logic [3:0] src;
  } aic_line_s;

  typedef struct packed {
    logic power;
    logic refsel;
    logic [3:0] code;
    logic [4:0] chan;
    aic_line_s [3:0] line;
    logic [3:0] flag;
    logic [3:0] ovf;
    logic [3:0] irq;
    logic [31:0] rdata;
    logic ref_hi;
    logic ref_lo;
  } aic_state_s;

  typedef struct packed {
    logic [3:0] last_code;
    logic [4:0] acc;
    logic tick;
  } aic_div_s;

endpackage
`default_nettype wire

// ---- include/aic_div_if.sv ----
// Link between the register block and the conversion clock divider
`default_nettype none
interface aic_div_if;
  logic [3:0] code;
  logic power;
  logic tick;
  modport ctrl (output code, output power, input tick);
  modport div (input code, input power, output tick);
endinterface
`default_nettype wire

// ---- hw/aic_clk_div.sv ----
// Conversion clock divider with half-step ratios
`default_nettype none
`include "aic_regs.svh"
module aic_clk_div (
  input wire logic pclk,
  input wire logic presetn,
  aic_div_if.div dv
);

  aic_pkg::aic_div_s st;
  aic_pkg::aic_div_s nx;
  logic [4:0] lim;
  logic [4:0] sum;

  // Ratio is (code + 2) / 2, counted in half cycles
  assign lim = {1'b0, dv.code} + 5'h02;
  assign sum = st.acc + 5'h02;

  always_comb
  begin
    nx = st;
    nx.last_code = dv.code;
    if (!dv.power || dv.code != st.last_code)
    begin
      // Restart on a new code so no burst follows a ratio change
      nx.acc = 5'h00;
      nx.tick = 1'b0;
    end
    else if (sum >= lim)
    begin
      nx.acc = sum - lim;
      nx.tick = 1'b1;
    end
    else
    begin
      nx.acc = sum;
      nx.tick = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= nx;
  end

  assign dv.tick = st.tick;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_code0_run;
    (dv.power && dv.code == 4'h0)[*3];
  endsequence
  sequence s_code2_run;
    (dv.power && dv.code == 4'h2)[*4] ##0 dv.tick;
  endsequence

  property p_div_one;
    s_code0_run |-> dv.tick;
  endproperty
  a_div_one: assert property (p_div_one) else $error("code 0 must tick every cycle");

  property p_div_two;
    s_code2_run |-> !$past(dv.tick);
  endproperty
  a_div_two: assert property (p_div_two) else $error("code 2 must tick every other cycle");

  property p_div_off;
    !dv.power |=> !dv.tick;
  endproperty
  a_div_off: assert property (p_div_off) else $error("tick while powered down");

endmodule // aic_clk_div
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench of the converter interrupt flag and clock control
`default_nettype none
`include "aic_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] eoc_pulse;
  logic [3:0] irq_pulse;
  logic converter_power_on;
  logic conversion_clock;
  logic [4:0] chan_select;
  logic ref_high_pin_route;
  logic ref_low_pin_route;
  logic ref_high_d;
  logic ref_low_d;
  logic [31:0] rd;
  logic er;
  int n_fail;
  int comparisons;

  aic_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eoc_pulse(eoc_pulse), .irq_pulse(irq_pulse),
    .converter_power_on(converter_power_on), .conversion_clock(conversion_clock),
    .chan_select(chan_select), .ref_high_pin_route(ref_high_pin_route),
    .ref_low_pin_route(ref_low_pin_route));

  // Second instance shares the bus; only its reference routing is judged
  aic_ctrl #(.INSTANCE(aic_pkg::AIC_INST_D)) u_dut_d (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(), .pready(), .pslverr(), .eoc_pulse(eoc_pulse), .irq_pulse(),
    .converter_power_on(), .conversion_clock(), .chan_select(),
    .ref_high_pin_route(ref_high_d), .ref_low_pin_route(ref_low_d));

  always #20 pclk = ~pclk;

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_count(input int got, input int exp, input string m);
    comparisons++;
    if (got != exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %0d want %0d", $time, m, got, exp);
    end
  endtask

  // Answer taken at the completing rising edge, before that edge's updates land
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic rdy;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle limit here: only the watchdog ends a hung access
    do
    begin
      @(posedge pclk);
      rdy = pready;
      rd = prdata;
      er = pslverr;
      n++;
    end while (rdy !== 1'b1);
    chk_count(n, 1, "access cycles");
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so no signal is driven twice in one step
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    chk_word(rd, exp, m);
  endtask

  task automatic pulse(input int s, input logic [3:0] exp, input string m);
    eoc_pulse <= 16'(16'h0001 << s);
    @(posedge pclk);
    eoc_pulse <= 16'h0000;
    @(negedge pclk);
    chk_word({28'h0, irq_pulse}, {28'h0, exp}, m);
    @(negedge pclk);
    chk_word({28'h0, irq_pulse}, 32'h0, "one cycle irq");
    @(posedge pclk);
  endtask

  task automatic t_regs();
    logic [7:0] ofs [6];
    ofs = '{`AIC_OFS_CTL1, `AIC_OFS_CTL2, `AIC_OFS_SEL12, `AIC_OFS_SEL34, `AIC_OFS_FLG,
      `AIC_OFS_CHAN};
    foreach (ofs[i])
    begin
      rdc(ofs[i], 32'h0, "reset value");
    end
    apb(1'b0, `AIC_OFS_OSD, 32'h0);
    chk_word({31'h0, er}, 32'h1, "missing register refused");
    chk_word(rd, 32'h0, "missing register data");
    wr(`AIC_OFS_FLG, 32'hF);
    rdc(`AIC_OFS_FLG, 32'h0, "flag read only");
    $display("test regs done");
  endtask

  task automatic t_nocont();
    wr(`AIC_OFS_SEL12, 32'h1613);
    pulse(3, 4'h1, "first event");
    rdc(`AIC_OFS_FLG, 32'h1, "flag set");
    pulse(3, 4'h0, "blocked by flag");
    rdc(`AIC_OFS_OVF, 32'h1, "overrun");
    pulse(6, 4'h2, "second line");
    pulse(4, 4'h0, "unselected source");
    wr(`AIC_OFS_FLGCLR, 32'h3);
    rdc(`AIC_OFS_FLG, 32'h0, "flag cleared");
    rdc(`AIC_OFS_OVF, 32'h1, "overrun held");
    wr(`AIC_OFS_OVFCLR, 32'h1);
    rdc(`AIC_OFS_OVF, 32'h0, "overrun cleared");
    pulse(3, 4'h1, "after clear");
    wr(`AIC_OFS_FLGCLR, 32'h1);
    $display("test nocont done");
  endtask

  task automatic t_cont();
    wr(`AIC_OFS_SEL34, 32'h1535);
    pulse(5, 4'hC, "both lines");
    pulse(5, 4'h4, "continue keeps going");
    pulse(5, 4'h4, "continue again");
    rdc(`AIC_OFS_OVF, 32'hC, "overrun both");
    wr(`AIC_OFS_FLGCLR, 32'hC);
    wr(`AIC_OFS_OVFCLR, 32'hC);
    rdc(`AIC_OFS_FLG, 32'h0, "flags cleared");
    wr(`AIC_OFS_SEL34, 32'h0);
    $display("test cont done");
  endtask

  task automatic t_collide();
    pulse(3, 4'h1, "set flag");
    // Event lands on the same edge that takes the clear write
    fork
      wr(`AIC_OFS_FLGCLR, 32'h1);
      begin
        @(posedge pclk);
        eoc_pulse <= 16'h0008;
        @(posedge pclk);
        eoc_pulse <= 16'h0000;
      end
    join
    rdc(`AIC_OFS_FLG, 32'h1, "set wins");
    rdc(`AIC_OFS_OVF, 32'h1, "loss seen");
    pulse(3, 4'h0, "still blocked");
    wr(`AIC_OFS_FLGCLR, 32'h1);
    rdc(`AIC_OFS_FLG, 32'h0, "second clear");
    pulse(3, 4'h1, "resumes");
    wr(`AIC_OFS_FLGCLR, 32'h1);
    wr(`AIC_OFS_OVFCLR, 32'h1);
    $display("test collide done");
  endtask

  task automatic t_div();
    int n;
    int want [4];
    want = '{30, 20, 15, 12};
    wr(`AIC_OFS_CTL1, 32'h1);
    chk_word({31'h0, converter_power_on}, 32'h1, "power");
    for (int c = 0; c < 4; c++)
    begin
      wr(`AIC_OFS_CTL2, 32'(c));
      repeat (6) @(posedge pclk);
      n = 0;
      // Window of 30 cycles is whole for every pattern period
      repeat (30)
      begin
        @(negedge pclk);
        n += int'(conversion_clock === 1'b1);
      end
      @(posedge pclk);
      chk_count(n, want[c], "ticks in 30 cycles");
    end
    wr(`AIC_OFS_CTL2, 32'h2);
    $display("test div done");
  endtask

  task automatic chk_ref(input logic [7:0] ch, input logic [1:0] exp, input logic [1:0] exp_d,
    input string m);
    wr(`AIC_OFS_CHAN, {24'h0, ch});
    @(negedge pclk);
    chk_word({25'h0, chan_select, ref_high_pin_route, ref_low_pin_route},
      {25'h0, ch[4:0], exp}, m);
    chk_word({30'h0, ref_high_d, ref_low_d}, {30'h0, exp_d}, m);
    @(posedge pclk);
  endtask

  task automatic t_ref();
    wr(`AIC_OFS_CTL1, 32'h3);
    chk_ref(8'h14, 2'b00, 2'b10, "high pin channel");
    chk_ref(8'h01, 2'b00, 2'b01, "low pin channel one");
    chk_ref(8'h0D, 2'b01, 2'b00, "low pin channel thirteen");
    wr(`AIC_OFS_CTL1, 32'h1);
    chk_ref(8'h0D, 2'b00, 2'b00, "reference mode off");
    $display("test ref done");
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (4000) @(posedge pclk);
    n_fail++;
    $display("wrong value at %0t: watchdog expired", $time);
    close_out();
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    eoc_pulse = 16'h0000;
    n_fail = 0;
    comparisons = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_nocont();
    t_cont();
    t_collide();
    t_div();
    t_ref();
    close_out();
  end
endmodule // testbench
`default_nettype wire
